// >>> sdc_pkg.sv
// Function
// - command set by pin levels at clock edge
// - cke action from state and two cke samples
// - low-low cke holds; low-high with des/nop exits
// - high-low with des/nop enters power-down kind
// - idle needs banks closed, quiet, timers done
// - termination input never affects cke transitions
// - self refresh exits asynchronously; no power-down refresh
// - deselect executes nothing; running work continues
// - nop registers nothing; running work continues
// - long zq calibrates then updates i/o values
// - short zq corrects within 64 cycles
// - activate opens addressed row in selected bank
// - read bursts from open row at column
// - a10 selects auto precharge after burst
// - a12 selects chop or full burst on-the-fly
// - registered read burst cut off by a new read to an open bank, which reloads burst_cnt and restarts the burst
// - read is cs low ras high cas low we high
`default_nettype none
package sdc_pkg;
  // =====================================================================
  // widths and field positions
  localparam int BANKS      = 8;
  localparam int BA_W       = 3;
  localparam int ADDR_W     = 16;
  localparam int COL_W      = 10;
  localparam int A10_POS    = 10;
  localparam int A12_POS    = 12;
  localparam int CNT_W      = 10;
  localparam int DESC_W     = BA_W + ADDR_W + COL_W + 2;
  localparam int BUF_DEPTH  = 2;
  // =====================================================================
  // timing, in link clock cycles unless noted
  localparam int BURST_CK   = 4;
  localparam int CHOP_CK    = 2;
  localparam int ZQINIT_CK  = 512;
  localparam int ZQOPER_CK  = 256;
  localparam int ZQCS_CK    = 64;
  localparam int TRFC_CK    = 8;
  localparam int TXP_CK     = 3;
  localparam int CLK_PS     = 5000;
  localparam int TREFI_PS   = 7800000;
  localparam int TREFI_CYC  = TREFI_PS / CLK_PS;
  // =====================================================================
  // types
  typedef enum {PS_ACTIVE, PS_PD_ACT, PS_PD_PRE, PS_SELF_REF} sdc_pwr_e;
  typedef enum {CMD_DES, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT,
                CMD_WR, CMD_RD, CMD_ZQ} sdc_cmd_e;
  typedef struct packed {
    logic [BA_W-1:0]   bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic              chop;
    logic              auto_pre;
  } sdc_rd_s;
endpackage
`default_nettype wire

// >>> sdc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> sdc_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_buf
  import sdc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  sdc_stream_if.snk in_s,
  sdc_stream_if.src out_s
);
  // =====================================================================
  // two-entry skid storage
  logic [DESC_W-1:0] mem [BUF_DEPTH];
  logic              wr_ptr;
  logic              rd_ptr;
  logic [1:0]        count;
  wire               push = in_s.valid && in_s.ready;
  wire               pop  = out_s.valid && out_s.ready;

  assign in_s.ready  = (count != 2'(BUF_DEPTH));
  assign out_s.valid = (count != 2'h0);
  assign out_s.data  = mem[rd_ptr];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_s.data;
        wr_ptr      <= !wr_ptr;
      end
      if (pop)
        rd_ptr <= !rd_ptr;
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> sdc_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_decode
  import sdc_pkg::*;
#(
  parameter int TREFI_CYCLES = TREFI_CYC
)
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              ck,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              odt,
  input  wire logic              otf_en,
  input  wire logic              bc4_fixed,
  output logic                   active_pd,
  output logic                   precharge_pd,
  output logic                   self_refresh,
  output logic                   dev_idle,
  output logic [BANKS-1:0]       bank_open,
  output logic                   burst_active,
  output logic                   beat_valid,
  output logic                   refresh_busy,
  output logic                   self_ref_tick,
  output logic                   zq_busy,
  output logic                   zq_update,
  output logic                   term_enable,
  output logic                   rd_overflow,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [DESC_W-1:0]      rd_desc
);
  // =====================================================================
  // pin synchronisers
  localparam int PIN_W = 7 + BA_W + ADDR_W;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic             ck_d;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      ck_d   <= 1'b0;
    end
    else
    begin
      pin_s1 <= {ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr};
      pin_s2 <= pin_s1;
      ck_d   <= pin_s2[PIN_W-1];
    end
  end

  wire              ck_s    = pin_s2[PIN_W-1];
  wire              cke_s   = pin_s2[PIN_W-2];
  wire              cs_s    = pin_s2[PIN_W-3];
  wire              ras_s   = pin_s2[PIN_W-4];
  wire              cas_s   = pin_s2[PIN_W-5];
  wire              we_s    = pin_s2[PIN_W-6];
  wire              odt_s   = pin_s2[PIN_W-7];
  wire [BA_W-1:0]   ba_s    = pin_s2[ADDR_W +: BA_W];
  wire [ADDR_W-1:0] addr_s  = pin_s2[ADDR_W-1:0];
  wire              ck_rise = ck_s && !ck_d;

  // =====================================================================
  // command decode
  sdc_cmd_e cmd;
  assign cmd = cs_s                           ? CMD_DES :
               ( ras_s &&  cas_s &&  we_s)    ? CMD_NOP :
               (!ras_s && !cas_s && !we_s)    ? CMD_MRS :
               (!ras_s && !cas_s &&  we_s)    ? CMD_REF :
               (!ras_s &&  cas_s && !we_s)    ? CMD_PRE :
               (!ras_s &&  cas_s &&  we_s)    ? CMD_ACT :
               ( ras_s && !cas_s && !we_s)    ? CMD_WR  :
               ( ras_s && !cas_s &&  we_s)    ? CMD_RD  :
                                                CMD_ZQ;

  logic     cke_prev;
  sdc_pwr_e pwr;
  sdc_pwr_e next_pwr;

  wire quiet     = (cmd == CMD_DES) || (cmd == CMD_NOP);
  wire cke_hh    = cke_prev && cke_s;
  wire cke_hl    = cke_prev && !cke_s;
  wire cke_lh    = !cke_prev && cke_s;
  wire run_cmd   = ck_rise && cke_hh && (pwr == PS_ACTIVE);
  wire do_act    = run_cmd && (cmd == CMD_ACT);
  wire do_rd     = run_cmd && (cmd == CMD_RD);
  wire do_pre    = run_cmd && (cmd == CMD_PRE);
  wire do_ref    = run_cmd && (cmd == CMD_REF);
  wire do_zq     = run_cmd && (cmd == CMD_ZQ);
  wire zq_long   = addr_s[A10_POS];
  wire rd_chop   = otf_en ? !addr_s[A12_POS] : bc4_fixed;
  wire any_open  = |bank_open;

  // =====================================================================
  // link timers
  logic [CNT_W-1:0] burst_cnt;
  logic [CNT_W-1:0] ref_cnt;
  logic [CNT_W-1:0] zq_cnt;
  logic [CNT_W-1:0] exit_cnt;
  logic             zq_init_done;
  logic             chop_q;
  logic             ap_q;
  logic [BA_W-1:0]  ap_bank;
  logic [31:0]      sr_cnt;

  wire burst_end = ck_rise && (burst_cnt == CNT_W'(1));
  wire ap_close  = burst_end && ap_q;

  assign burst_active = (burst_cnt != '0);
  assign refresh_busy = (ref_cnt != '0);
  assign zq_busy      = (zq_cnt != '0);
  // idle apart from the clock-enable level, which the caller qualifies
  wire idle_core = (pwr == PS_ACTIVE) && !any_open && !burst_active
                   && !refresh_busy && !zq_busy && (exit_cnt == '0);

  // =====================================================================
  // clock-enable state transitions
  always_comb
  begin
    next_pwr = pwr;
    case (pwr)
      PS_PD_ACT, PS_PD_PRE:
      begin
        if (ck_rise && cke_lh && quiet)
          next_pwr = PS_ACTIVE;
      end
      PS_SELF_REF:
      begin
        if (cke_s)
          next_pwr = PS_ACTIVE;
      end
      default:
      begin
        if (ck_rise && cke_hl)
        begin
          if (quiet)
            next_pwr = (any_open && !refresh_busy) ? PS_PD_ACT
                                                   : PS_PD_PRE;
          else if ((cmd == CMD_REF) && idle_core)
            next_pwr = PS_SELF_REF;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pwr      <= PS_ACTIVE;
      cke_prev <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      if (ck_rise)
        cke_prev <= cke_s;
    end
  end

  assign active_pd    = (pwr == PS_PD_ACT);
  assign precharge_pd = (pwr == PS_PD_PRE);
  assign self_refresh = (pwr == PS_SELF_REF);
  assign dev_idle     = idle_core && cke_s;
  assign term_enable  = odt_s;

  // =====================================================================
  // banks and open rows
  logic [ADDR_W-1:0] open_row [BANKS];

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      wire hit = (ba_s == BA_W'(b));
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          bank_open[b] <= 1'b0;
          open_row[b]  <= '0;
        end
        else if (do_act && hit)
        begin
          bank_open[b] <= 1'b1;
          open_row[b]  <= addr_s;
        end
        else if ((do_pre && (hit || addr_s[A10_POS]))
                 || (ap_close && (ap_bank == BA_W'(b))))
          bank_open[b] <= 1'b0;
      end
    end
  endgenerate

  // =====================================================================
  // read burst timing
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      burst_cnt <= '0;
      chop_q    <= 1'b0;
      ap_q      <= 1'b0;
      ap_bank   <= '0;
    end
    else if (do_rd && bank_open[ba_s])
    begin
      burst_cnt <= CNT_W'(BURST_CK);
      chop_q    <= rd_chop;
      ap_q      <= addr_s[A10_POS];
      ap_bank   <= ba_s;
    end
    else if (ck_rise && burst_active)
      burst_cnt <= burst_cnt - CNT_W'(1);
  end

  assign beat_valid = burst_active
                      && (!chop_q || (burst_cnt > CNT_W'(BURST_CK - CHOP_CK)));

  // =====================================================================
  // refresh, calibration and exit timers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ref_cnt      <= '0;
      zq_cnt       <= '0;
      zq_init_done <= 1'b0;
      zq_update    <= 1'b0;
      exit_cnt     <= '0;
    end
    else
    begin
      zq_update <= ck_rise && (zq_cnt == CNT_W'(1));
      if (do_ref)
        ref_cnt <= CNT_W'(TRFC_CK);
      else if (ck_rise && refresh_busy)
        ref_cnt <= ref_cnt - CNT_W'(1);
      if (do_zq && zq_long)
      begin
        zq_cnt       <= zq_init_done ? CNT_W'(ZQOPER_CK) : CNT_W'(ZQINIT_CK);
        zq_init_done <= 1'b1;
      end
      else if (do_zq)
        zq_cnt <= CNT_W'(ZQCS_CK);
      else if (ck_rise && zq_busy)
        zq_cnt <= zq_cnt - CNT_W'(1);
      if ((pwr != PS_ACTIVE) && (next_pwr == PS_ACTIVE))
        exit_cnt <= CNT_W'(TXP_CK);
      else if (ck_rise && (exit_cnt != '0))
        exit_cnt <= exit_cnt - CNT_W'(1);
    end
  end

  // internal refresh runs in self refresh only, never in power-down
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sr_cnt        <= '0;
      self_ref_tick <= 1'b0;
    end
    else if (self_refresh && (next_pwr == PS_SELF_REF))
    begin
      self_ref_tick <= (sr_cnt == 32'(TREFI_CYCLES - 1));
      sr_cnt        <= (sr_cnt == 32'(TREFI_CYCLES - 1)) ? '0 : sr_cnt + 32'h1;
    end
    else
    begin
      sr_cnt        <= '0;
      self_ref_tick <= 1'b0;
    end
  end

  // =====================================================================
  // read descriptor stream
  sdc_stream_if #(.W(DESC_W)) fill_s ();
  sdc_stream_if #(.W(DESC_W)) drain_s ();

  logic    pend_valid;
  sdc_rd_s pend_desc;
  sdc_rd_s new_desc;

  assign new_desc.bank     = ba_s;
  assign new_desc.row      = open_row[ba_s];
  assign new_desc.col      = addr_s[COL_W-1:0];
  assign new_desc.chop     = rd_chop;
  assign new_desc.auto_pre = addr_s[A10_POS];

  wire rd_take = do_rd && bank_open[ba_s];
  wire sent    = pend_valid && fill_s.ready;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pend_valid  <= 1'b0;
      pend_desc   <= '0;
      rd_overflow <= 1'b0;
    end
    else
    begin
      if (rd_take && (!pend_valid || sent))
      begin
        pend_valid <= 1'b1;
        pend_desc  <= new_desc;
      end
      else if (sent)
        pend_valid <= 1'b0;
      if (rd_take && pend_valid && !sent)
        rd_overflow <= 1'b1;
    end
  end

  assign fill_s.valid  = pend_valid;
  assign fill_s.data   = pend_desc;
  assign rd_valid      = drain_s.valid;
  assign rd_desc       = drain_s.data;
  assign drain_s.ready = rd_ready;

  sdc_buf sdc_buf_inst
  (
    .core_clk (core_clk),
    .reset    (reset),
    .in_s     (fill_s),
    .out_s    (drain_s)
  );
endmodule
`default_nettype wire

// >>> sdc_cmd_decode_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_decode_asserts
  import sdc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              cke,
  input wire logic              active_pd,
  input wire logic              precharge_pd,
  input wire logic              self_refresh,
  input wire logic              dev_idle,
  input wire logic [BANKS-1:0]  bank_open,
  input wire logic              burst_active,
  input wire logic              beat_valid,
  input wire logic              refresh_busy,
  input wire logic              self_ref_tick,
  input wire logic              zq_busy,
  input wire logic              zq_update,
  input wire logic              rd_valid,
  input wire logic              rd_ready,
  input wire logic [DESC_W-1:0] rd_desc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // =====================================================================
  // sequences
  sequence burst_hold;
    burst_active [*8];
  endsequence
  sequence cke_low_run;
    !cke [*4];
  endsequence
  // =====================================================================
  // properties
  pwr_onehot_a: assert property ($onehot0({active_pd, precharge_pd, self_refresh}))
    else $error("more than one power state");
  idle_quiet_a: assert property (dev_idle |-> bank_open == '0 && !burst_active
    && !refresh_busy && !zq_busy && !active_pd && !precharge_pd && !self_refresh)
    else $error("idle while busy");
  beat_in_burst_a: assert property (beat_valid |-> burst_active)
    else $error("beat outside burst");
  burst_whole_a: assert property ($rose(burst_active) |-> burst_hold)
    else $error("burst cut short");
  zq_pulse_a: assert property (zq_update |=> !zq_update)
    else $error("update pulse too long");
  zq_end_a: assert property ($fell(zq_busy) |-> ##[0:2] zq_update)
    else $error("no update after calibration");
  tick_in_sr_a: assert property (self_ref_tick |-> self_refresh)
    else $error("refresh tick outside self refresh");
  sr_exit_a: assert property (self_refresh && cke |-> ##[0:4] !self_refresh)
    else $error("self refresh exit late");
  pd_hold_a: assert property (cke_low_run ##0 (active_pd || precharge_pd)
    |=> (active_pd || precharge_pd))
    else $error("power-down left with clock enable low");
  rd_stall_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_desc))
    else $error("descriptor lost under stall");
endmodule
bind sdc_cmd_decode sdc_cmd_decode_asserts sdc_cmd_decode_asserts_inst (
  .core_clk(core_clk), .reset(reset), .cke(cke), .active_pd(active_pd),
  .precharge_pd(precharge_pd), .self_refresh(self_refresh), .dev_idle(dev_idle),
  .bank_open(bank_open), .burst_active(burst_active), .beat_valid(beat_valid),
  .refresh_busy(refresh_busy), .self_ref_tick(self_ref_tick), .zq_busy(zq_busy),
  .zq_update(zq_update), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_desc(rd_desc)
);
`default_nettype wire

// >>> sdc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model
  import sdc_pkg::*;
(
  output logic              ck,
  output logic              cke,
  output logic              cs_n,
  output logic              ras_n,
  output logic              cas_n,
  output logic              we_n,
  output logic [BA_W-1:0]   ba,
  output logic [ADDR_W-1:0] addr,
  output logic              odt
);
  initial
  begin
    ck = 1'h0;
    cke = 1'h0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = '0;
    addr = '0;
    odt = 1'h0;
  end
  always #80 ck = ~ck;
  // pins change on the falling edge, held through the rising edge that registers them
  task automatic cmd(input logic [3:0] c, input logic ke, input logic [BA_W-1:0] b,
                     input logic [ADDR_W-1:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= c;
    cke <= ke;
    ba <= b;
    addr <= a;
    @(posedge ck);
    @(negedge ck);
    cs_n <= 1'h1;
    ba <= ~b;
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

// >>> sdc_cmd_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_decode_test
  import sdc_pkg::*;
;
  localparam logic [3:0] op_nop = 4'h7;
  localparam logic [3:0] op_des = 4'hF;
  localparam logic [3:0] op_act = 4'h3;
  localparam logic [3:0] op_rd  = 4'h5;
  localparam logic [3:0] op_ref = 4'h1;
  localparam logic [3:0] op_zq  = 4'h6;
  localparam logic [3:0] op_pre = 4'h2;
  logic              core_clk = 1'h0;
  logic              reset, otf_en, bc4_fixed, rd_ready, tick_seen, zq_seen;
  logic              ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              active_pd, precharge_pd, self_refresh, dev_idle, burst_active;
  logic              beat_valid, refresh_busy, self_ref_tick, zq_busy, zq_update;
  logic              term_enable, rd_overflow, rd_valid;
  logic [BANKS-1:0]  bank_open;
  logic [DESC_W-1:0] rd_desc;
  int                n_mismatch, checked, cycles;
  always #2.5 core_clk = ~core_clk;
  sdc_ctrl_model sdc_ctrl_model_inst (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));
  sdc_cmd_decode #(.TREFI_CYCLES(20)) sdc_cmd_decode_inst (.core_clk(core_clk),
    .reset(reset), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .otf_en(otf_en), .bc4_fixed(bc4_fixed),
    .active_pd(active_pd), .precharge_pd(precharge_pd), .self_refresh(self_refresh),
    .dev_idle(dev_idle), .bank_open(bank_open), .burst_active(burst_active),
    .beat_valid(beat_valid), .refresh_busy(refresh_busy), .self_ref_tick(self_ref_tick),
    .zq_busy(zq_busy), .zq_update(zq_update), .term_enable(term_enable),
    .rd_overflow(rd_overflow), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_desc(rd_desc));
  // =====================================================================
  // checking and closing
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (self_ref_tick === 1'h1) tick_seen = 1'h1;
    if (zq_update === 1'h1) zq_seen = 1'h1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  // =====================================================================
  // scenarios
  task automatic zq_run(input logic a10, input int len);
    int n;
    n = 0;
    zq_seen = 1'h0;
    sdc_ctrl_model_inst.cmd(op_zq, 1'h1, 3'h0, {5'h00, a10, 10'h000});
    while (zq_busy === 1'h1 && n < 600)
    begin
      @(posedge ck);
      n++;
    end
    cmp("zq_window", 32'h1, 32'(n >= len - 2 && n <= len + 2));
    repeat (6) @(posedge core_clk);
    cmp("zq_update", 32'h1, 32'(zq_seen));
  endtask
  task automatic t_init;
    repeat (2) sdc_ctrl_model_inst.cmd(op_nop, 1'h1, 3'h0, 16'h0000);
    cmp("dev_idle", 32'h1, 32'(dev_idle));
    zq_run(1'h1, ZQINIT_CK);
    zq_run(1'h0, ZQCS_CK);
    zq_run(1'h1, ZQOPER_CK);
  endtask
  task automatic rd(input logic [2:0] b, input logic a12, input logic a10, input logic [9:0] c);
    sdc_ctrl_model_inst.cmd(op_rd, 1'h1, b, {3'h0, a12, 1'h0, a10, c});
    repeat (3) @(posedge ck);
  endtask
  task automatic t_read;
    sdc_ctrl_model_inst.cmd(op_act, 1'h1, 3'h3, 16'h1234);
    cmp("bank_open", 32'h08, 32'(bank_open));
    @(posedge core_clk) otf_en <= 1'h1;
    for (int i = 1; i <= 4; i++) rd(3'h3, i[0], 1'h0, i[9:0]);
    cmp("rd_overflow", 32'h1, 32'(rd_overflow));
    for (int i = 1; i <= 3; i++)
    begin
      @(posedge core_clk);
      #1;
      cmp("rd_desc", {1'h1, 3'h3, 16'h1234, i[9:0], ~i[0], 1'h0}, {rd_valid, rd_desc});
      @(posedge core_clk) rd_ready <= 1'h1;
      @(posedge core_clk) rd_ready <= 1'h0;
    end
    @(posedge core_clk);
    #1;
    cmp("rd_valid", 32'h0, 32'(rd_valid));
    @(posedge core_clk)
    begin
      otf_en <= 1'h0;
      bc4_fixed <= 1'h1;
      rd_ready <= 1'h1;
    end
    sdc_ctrl_model_inst.cmd(op_rd, 1'h1, 3'h3, 16'h17FF);
    repeat (2) @(posedge ck);
    #30;
    cmp("burst_beat", 32'h2, 32'({burst_active, beat_valid}));
    repeat (3) @(posedge ck);
    #30;
    cmp("bank_open", 32'h0, 32'(bank_open));
  endtask
  task automatic t_power;
    sdc_ctrl_model_inst.cmd(op_act, 1'h1, 3'h5, 16'h0042);
    sdc_ctrl_model_inst.cmd(op_nop, 1'h0, 3'h0, 16'h0000);
    cmp("pwr", 32'h4, 32'({active_pd, precharge_pd, self_refresh}));
    sdc_ctrl_model_inst.cmd(op_des, 1'h0, 3'h0, 16'h0000);
    cmp("pwr", 32'h4, 32'({active_pd, precharge_pd, self_refresh}));
    sdc_ctrl_model_inst.cmd(op_nop, 1'h1, 3'h0, 16'h0000);
    cmp("pwr", 32'h0, 32'({active_pd, precharge_pd, self_refresh}));
    repeat (4) @(posedge ck);
    sdc_ctrl_model_inst.cmd(op_pre, 1'h1, 3'h0, 16'h0400);
    sdc_ctrl_model_inst.odt <= 1'h1;
    sdc_ctrl_model_inst.cmd(op_ref, 1'h1, 3'h0, 16'h0000);
    cmp("refresh_busy", 32'h1, 32'(refresh_busy));
    sdc_ctrl_model_inst.cmd(op_des, 1'h0, 3'h0, 16'h0000);
    cmp("pwr", 32'h2, 32'({active_pd, precharge_pd, self_refresh}));
    cmp("term_enable", 32'h1, 32'(term_enable));
    sdc_ctrl_model_inst.cmd(op_nop, 1'h1, 3'h0, 16'h0000);
    repeat (6) @(posedge ck);
    cmp("dev_idle", 32'h1, 32'(dev_idle));
    tick_seen = 1'h0;
    sdc_ctrl_model_inst.cmd(op_ref, 1'h0, 3'h0, 16'h0000);
    cmp("pwr", 32'h1, 32'({active_pd, precharge_pd, self_refresh}));
    repeat (50) @(posedge core_clk);
    cmp("self_ref_tick", 32'h1, 32'(tick_seen));
    @(posedge ck);
    #20 sdc_ctrl_model_inst.cke <= 1'h1;
    #25;
    cmp("self_refresh", 32'h0, 32'(self_refresh));
  endtask
  // =====================================================================
  // main sequence
  initial
  begin
    reset = 1'h1;
    otf_en = 1'h0;
    bc4_fixed = 1'h0;
    rd_ready = 1'h0;
    tick_seen = 1'h0;
    zq_seen = 1'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    t_init;
    t_read;
    t_power;
    test_done;
  end
endmodule
`default_nettype wire
